// ===== sap_params.svh
/*
 * Offsets, field positions, reset values and word lengths of the
 * serial audio input port. Included by the package and the register slave.
 */
`ifndef SAP_PARAMS_SVH
`define SAP_PARAMS_SVH

`define SAP_OFF_CTRL    8'h00
`define SAP_OFF_STATUS  8'h04
`define SAP_OFF_LEFT    8'h08
`define SAP_OFF_RIGHT   8'h0C

`define SAP_CTRL_FMT_HI 3
`define SAP_CTRL_FMT_LO 2
`define SAP_CTRL_WL_HI  1
`define SAP_CTRL_WL_LO  0
`define SAP_CTRL_RESET  4'h0

`define SAP_SAMPLE_W    24
`define SAP_WL_24       5'h18
`define SAP_WL_20       5'h14
`define SAP_WL_16       5'h10

`endif

// ===== sap_pkg.sv
/*
 * Types and the slot-window decoder of the serial audio input port.
 * Assumes sap_params.svh is on the include path.
 */
`include "sap_params.svh"

package sap_pkg;

    typedef enum logic [1:0] {
        SAP_FMT_LJ  = 2'h0,
        SAP_FMT_I2S = 2'h1,
        SAP_FMT_RJ  = 2'h2,
        SAP_FMT_DSP = 2'h3
    } sap_fmt_type;

    typedef enum logic {
        SAP_BUS_IDLE = 1'b0,
        SAP_BUS_ACK  = 1'b1
    } sap_bus_type;

    typedef struct packed {
        logic       hit;
        logic       right;
        logic [4:0] off;
    } sap_win_type;

    function automatic logic [4:0] sap_wl_bits(input logic [1:0] code);
        logic [4:0] wl;
        wl = `SAP_WL_16;
        if (code == 2'h0) begin
            wl = `SAP_WL_24;
        end else if (code == 2'h1) begin
            wl = `SAP_WL_20;
        end
        return wl;
    endfunction

    // Where a bit position falls inside the frame for each format
    function automatic sap_win_type sap_window(input sap_fmt_type f,
                                               input logic        lr,
                                               input logic [5:0]  pos,
                                               input logic [5:0]  slot,
                                               input logic [4:0]  wl);
        sap_win_type w;
        logic [5:0]  start;
        logic [5:0]  rel;
        start   = 6'h00;
        w.right = ~lr;
        unique case (f)
            SAP_FMT_LJ: begin
                start = 6'h00;
            end
            SAP_FMT_I2S: begin
                start   = 6'h01;
                w.right = lr;
            end
            SAP_FMT_RJ: begin
                start = slot - {1'b0, wl};
            end
            SAP_FMT_DSP: begin
                w.right = (pos >= ({1'b0, wl} + 6'h01));
                start   = w.right ? ({1'b0, wl} + 6'h01) : 6'h01;
            end
        endcase
        rel   = pos - start;
        w.hit = (pos >= start) && (rel < {1'b0, wl});
        w.off = rel[4:0];
        return w;
    endfunction

endpackage

// ===== sap_reg_if.sv
/*
 * Carrier between the register slave and the port core.
 * Both ends run on clk_i.
 */
`timescale 1ns/1ps
`default_nettype none

interface sap_reg_if import sap_pkg::*;;
    sap_fmt_type fmt;
    logic [1:0]  wlen;
    logic [23:0] left;
    logic [23:0] right;
    logic        sel_sync;
    logic [15:0] frame_cnt;

    modport regs (output fmt, output wlen,
                  input left, input right, input sel_sync, input frame_cnt);
    modport core (input fmt, input wlen,
                  output left, output right, output sel_sync, output frame_cnt);
endinterface

`default_nettype wire

// ===== sap_regs.sv
/*
 * Classic Wishbone register slave of the serial audio input port.
 * Assumes a master that holds each request until ack and idles a cycle after.
 */
`include "sap_params.svh"
`timescale 1ns/1ps
`default_nettype none

module sap_regs import sap_pkg::*; (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic [7:0]  adr_i,
    input  wire logic [31:0] dat_i,
    input  wire logic        we_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    output logic      [31:0] dat_o,
    output logic             ack_o,
    sap_reg_if.regs          rif
);

    sap_bus_type bus_r;
    sap_bus_type bus_nxt;
    logic [3:0]  ctrl_r;
    logic [3:0]  ctrl_nxt;
    logic [31:0] rdat_r;
    logic [31:0] rdat_nxt;
    logic [7:0]  addr;

    assign addr = {adr_i[7:2], 2'b00};

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        bus_nxt  = SAP_BUS_IDLE;
        ctrl_nxt = ctrl_r;
        rdat_nxt = rdat_r;
        if (bus_r == SAP_BUS_IDLE && cyc_i && stb_i) begin
            bus_nxt = SAP_BUS_ACK;
            case (addr)
                `SAP_OFF_CTRL:   rdat_nxt = {28'h0000000, ctrl_r};
                `SAP_OFF_STATUS: rdat_nxt = {rif.frame_cnt, 15'h0000, rif.sel_sync};
                `SAP_OFF_LEFT:   rdat_nxt = {8'h00, rif.left};
                `SAP_OFF_RIGHT:  rdat_nxt = {8'h00, rif.right};
                default:         rdat_nxt = 32'h00000000;
            endcase
        end
        // Write lands on the edge where the master sees ack
        if (bus_r == SAP_BUS_ACK && cyc_i && stb_i && we_i && addr == `SAP_OFF_CTRL
            && sel_i[0]) begin
            ctrl_nxt = dat_i[3:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bus_r  <= SAP_BUS_IDLE;
            ctrl_r <= `SAP_CTRL_RESET;
            rdat_r <= 32'h00000000;
        end else begin
            bus_r  <= bus_nxt;
            ctrl_r <= ctrl_nxt;
            rdat_r <= rdat_nxt;
        end
    end

    assign ack_o    = (bus_r == SAP_BUS_ACK);
    assign dat_o    = rdat_r;
    assign rif.fmt  = sap_fmt_type'(ctrl_r[`SAP_CTRL_FMT_HI:`SAP_CTRL_FMT_LO]);
    assign rif.wlen = ctrl_r[`SAP_CTRL_WL_HI:`SAP_CTRL_WL_LO];

    ////////////////////////////////////////////////////////////////////////
    property p_ack_next;
        @(posedge clk_i) disable iff (rst_i)
        (cyc_i && stb_i && !ack_o) |=> ack_o ##1 !ack_o;
    endproperty
    a_ack_next: assert property (p_ack_next) else $error("ack not one cycle after request");

    property p_ctrl_write;
        @(posedge clk_i) disable iff (rst_i)
        (ack_o && cyc_i && stb_i && we_i && addr == `SAP_OFF_CTRL && sel_i[0])
            |=> (rif.fmt == $past(dat_i[3:2])) && (rif.wlen == $past(dat_i[1:0]));
    endproperty
    a_ctrl_write: assert property (p_ctrl_write) else $error("format field not written");

    property p_unmapped;
        @(posedge clk_i) disable iff (rst_i)
        (ack_o && addr > `SAP_OFF_RIGHT) |-> (dat_o == 32'h00000000);
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

endmodule

`default_nettype wire

// ===== sap_port.sv
/*
 * Serial audio input port: Wishbone registers, bit-clock domain framing
 * for four formats, sample capture and converter playback on the data line.
 * Assumes bit clock and frame clock come from the far source (port is slave);
 * the frame clock and data change with the bit clock and are read in its domain.
 */
// Local design decisions: the Wishbone slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none

module sap_port import sap_pkg::*; (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    input  wire logic        wb_we_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    output logic             wb_ack_o,
    input  wire logic        bit_clk_i,
    output logic             bit_clk_o,
    output logic             bit_clk_oe_n_o,
    input  wire logic        frame_clk_i,
    output logic             frame_clk_o,
    output logic             frame_clk_oe_n_o,
    input  wire logic        serial_sample_line_i,
    output logic             serial_sample_line_o,
    output logic             serial_sample_line_oe_n_o,
    input  wire logic        digital_source_select_i,
    input  wire logic [23:0] adc_left_i,
    input  wire logic [23:0] adc_right_i,
    output logic      [23:0] rx_left_o,
    output logic      [23:0] rx_right_o,
    output logic             rx_valid_o
);

    sap_reg_if rif ();

    sap_regs u_regs (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .adr_i (wb_adr_i),
        .dat_i (wb_dat_i),
        .we_i  (wb_we_i),
        .sel_i (wb_sel_i),
        .cyc_i (wb_cyc_i),
        .stb_i (wb_stb_i),
        .dat_o (wb_dat_o),
        .ack_o (wb_ack_o),
        .rif   (rif)
    );

    // Clocks are slave-only here; their pin drivers stay released
    assign bit_clk_o        = 1'b0;
    assign bit_clk_oe_n_o   = 1'b1;
    assign frame_clk_o      = 1'b0;
    assign frame_clk_oe_n_o = 1'b1;

    ////////////////////////////////////////////////////////////////////////
    // Link domain: reset and quasi-static configuration crossing
    logic        lrst_meta_r;
    logic        lrst_r;
    logic [3:0]  cfg_meta_r;
    logic [3:0]  cfg_r;
    logic [2:0]  txt_s_r;
    logic        tx_tgl_r;

    always_ff @(posedge bit_clk_i) begin
        lrst_meta_r <= rst_i;
        lrst_r      <= lrst_meta_r;
        // Format changes should be made while the source is idle
        cfg_meta_r  <= {rif.fmt, rif.wlen};
        cfg_r       <= cfg_meta_r;
        txt_s_r     <= {txt_s_r[1:0], tx_tgl_r};
    end

    sap_fmt_type lfmt;
    logic [4:0]  wl;
    assign lfmt = sap_fmt_type'(cfg_r[3:2]);
    assign wl   = sap_wl_bits(cfg_r[1:0]);

    ////////////////////////////////////////////////////////////////////////
    // Link domain: receive framing
    logic        lr_d_r;
    logic        lr_d_nxt;
    logic [5:0]  pos_r;
    logic [5:0]  pos_nxt;
    logic [5:0]  slot_r;
    logic [5:0]  slot_nxt;
    logic [23:0] sh_r;
    logic [23:0] sh_nxt;
    logic [23:0] lword_r;
    logic [23:0] lword_nxt;
    logic [23:0] rword_r;
    logic [23:0] rword_nxt;
    logic [23:0] txl_r;
    logic [23:0] txl_nxt;
    logic [23:0] txr_r;
    logic [23:0] txr_nxt;
    logic        frm_tgl_r;
    logic        frm_tgl_nxt;
    logic        lr_edge;
    logic [5:0]  pos;
    sap_win_type rx_win;
    logic        word_done;
    logic        msb_now;
    logic [23:0] txh_l_r;
    logic [23:0] txh_r_r;
    logic        rdone;

    // DSP mode frames on the sync pulse's rising edge only
    assign lr_edge   = (lfmt == SAP_FMT_DSP) ? (frame_clk_i & ~lr_d_r)
                                             : (frame_clk_i ^ lr_d_r);
    assign pos       = lr_edge ? 6'h00 : pos_r;
    assign rx_win    = sap_window(lfmt, frame_clk_i, pos, slot_r, wl);
    assign word_done = rx_win.hit && (rx_win.off == (wl - 5'h01));
    assign msb_now   = sh_r[5'(wl - 5'h02)];
    assign rdone     = rx_win.right && word_done;

    always_comb begin
        lr_d_nxt    = frame_clk_i;
        pos_nxt     = (pos == 6'h3F) ? pos : pos + 6'h01;
        slot_nxt    = lr_edge ? pos_r : slot_r;
        sh_nxt      = sh_r;
        lword_nxt   = lword_r;
        rword_nxt   = rword_r;
        frm_tgl_nxt = frm_tgl_r;
        txl_nxt     = txl_r;
        txr_nxt     = txr_r;
        if (rx_win.hit) begin
            sh_nxt = {sh_r[22:0], serial_sample_line_i};
        end
        if (word_done) begin
            // MSB-aligned keeps the sign bit at bit 23
            if (rx_win.right) begin
                rword_nxt   = sh_nxt << (5'h18 - wl);
                frm_tgl_nxt = ~frm_tgl_r;
            end else begin
                lword_nxt = sh_nxt << (5'h18 - wl);
            end
        end
        if (txt_s_r[1] ^ txt_s_r[2]) begin
            txl_nxt = txh_l_r;
            txr_nxt = txh_r_r;
        end
    end

    always_ff @(posedge bit_clk_i) begin
        if (lrst_r) begin
            lr_d_r    <= 1'b0;
            pos_r     <= 6'h00;
            slot_r    <= 6'h00;
            sh_r      <= 24'h000000;
            lword_r   <= 24'h000000;
            rword_r   <= 24'h000000;
            frm_tgl_r <= 1'b0;
            txl_r     <= 24'h000000;
            txr_r     <= 24'h000000;
        end else begin
            lr_d_r    <= lr_d_nxt;
            pos_r     <= pos_nxt;
            slot_r    <= slot_nxt;
            sh_r      <= sh_nxt;
            lword_r   <= lword_nxt;
            rword_r   <= rword_nxt;
            frm_tgl_r <= frm_tgl_nxt;
            txl_r     <= txl_nxt;
            txr_r     <= txr_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Link domain: converter samples out, launched on the falling edge
    logic        wrap;
    logic [5:0]  np;
    logic        nlr;
    sap_win_type tx_win;
    logic        txbit_r;
    logic        txbit_nxt;

    // Next slot start is predicted from the last slot length
    assign wrap   = (slot_r != 6'h00) && (pos_r >= slot_r);
    assign np     = wrap ? 6'h00 : pos_r;
    assign nlr    = wrap ? ~lr_d_r : lr_d_r;
    assign tx_win = sap_window(lfmt, nlr, np, slot_r, wl);

    always_comb begin
        txbit_nxt = 1'b0;
        if (tx_win.hit) begin
            txbit_nxt = tx_win.right ? txr_r[5'(5'h17 - tx_win.off)]
                                     : txl_r[5'(5'h17 - tx_win.off)];
        end
    end

    always_ff @(negedge bit_clk_i) begin
        if (lrst_r) begin
            txbit_r <= 1'b0;
        end else begin
            txbit_r <= txbit_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // System domain: frame event, select pin, sample hand-off
    logic [2:0]  frm_s_r;
    logic        frm_evt;
    logic        sel_meta_r;
    logic        sel_r;
    logic        drive_r;
    logic        drive_nxt;
    logic [23:0] left_r;
    logic [23:0] left_nxt;
    logic [23:0] right_r;
    logic [23:0] right_nxt;
    logic        valid_r;
    logic        valid_nxt;
    logic [15:0] cnt_r;
    logic [15:0] cnt_nxt;
    logic [23:0] txh_l_nxt;
    logic [23:0] txh_r_nxt;
    logic        tx_tgl_nxt;

    always_ff @(posedge clk_i) begin
        frm_s_r    <= {frm_s_r[1:0], frm_tgl_r};
        sel_meta_r <= digital_source_select_i;
        sel_r      <= sel_meta_r;
    end

    assign frm_evt = frm_s_r[1] ^ frm_s_r[2];

    always_comb begin
        drive_nxt  = ~sel_r;
        left_nxt   = left_r;
        right_nxt  = right_r;
        valid_nxt  = 1'b0;
        cnt_nxt    = cnt_r;
        txh_l_nxt  = txh_l_r;
        txh_r_nxt  = txh_r_r;
        tx_tgl_nxt = tx_tgl_r;
        // Link words hold a whole half frame, so no tearing here
        if (frm_evt) begin
            left_nxt   = lword_r;
            right_nxt  = rword_r;
            valid_nxt  = sel_r;
            cnt_nxt    = cnt_r + 16'h0001;
            txh_l_nxt  = adc_left_i;
            txh_r_nxt  = adc_right_i;
            tx_tgl_nxt = ~tx_tgl_r;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            drive_r  <= 1'b0;
            left_r   <= 24'h000000;
            right_r  <= 24'h000000;
            valid_r  <= 1'b0;
            cnt_r    <= 16'h0000;
            txh_l_r  <= 24'h000000;
            txh_r_r  <= 24'h000000;
            tx_tgl_r <= 1'b0;
        end else begin
            drive_r  <= drive_nxt;
            left_r   <= left_nxt;
            right_r  <= right_nxt;
            valid_r  <= valid_nxt;
            cnt_r    <= cnt_nxt;
            txh_l_r  <= txh_l_nxt;
            txh_r_r  <= txh_r_nxt;
            tx_tgl_r <= tx_tgl_nxt;
        end
    end

    assign serial_sample_line_o      = txbit_r & drive_r;
    assign serial_sample_line_oe_n_o = ~drive_r;
    assign rx_left_o                 = left_r;
    assign rx_right_o                = right_r;
    assign rx_valid_o                = valid_r;
    assign rif.left                  = left_r;
    assign rif.right                 = right_r;
    assign rif.sel_sync              = sel_r;
    assign rif.frame_cnt             = cnt_r;

    ////////////////////////////////////////////////////////////////////////
    property p_release;
        @(posedge clk_i) disable iff (rst_i)
        sel_r |=> serial_sample_line_oe_n_o && !serial_sample_line_o;
    endproperty
    a_release: assert property (p_release) else $error("line not released");

    property p_drive;
        @(posedge clk_i) disable iff (rst_i)
        !sel_r |=> !serial_sample_line_oe_n_o;
    endproperty
    a_drive: assert property (p_drive) else $error("converter not driving line");

    property p_valid_sel;
        @(posedge clk_i) disable iff (rst_i)
        rx_valid_o |-> $past(sel_r) && (rx_left_o == $past(lword_r));
    endproperty
    a_valid_sel: assert property (p_valid_sel) else $error("sample without select");

    property p_tgl_right;
        @(posedge bit_clk_i) disable iff (lrst_r)
        $changed(frm_tgl_r) |-> $past(rdone);
    endproperty
    a_tgl_right: assert property (p_tgl_right) else $error("frame end off right slot");

    property p_lj_msb;
        @(posedge bit_clk_i) disable iff (lrst_r)
        (lfmt == SAP_FMT_LJ && lr_edge) |-> rx_win.hit && rx_win.off == 5'h00;
    endproperty
    a_lj_msb: assert property (p_lj_msb) else $error("left-justified MSB misplaced");

    property p_i2s_delay;
        @(posedge bit_clk_i) disable iff (lrst_r)
        (lfmt == SAP_FMT_I2S && lr_edge) |-> !rx_win.hit ##1 rx_win.hit;
    endproperty
    a_i2s_delay: assert property (p_i2s_delay) else $error("I2S one-bit delay broken");

    property p_slot;
        @(posedge bit_clk_i) disable iff (lrst_r)
        lr_edge |=> slot_r == $past(pos_r);
    endproperty
    a_slot: assert property (p_slot) else $error("slot length not measured");

    property p_rj_tail;
        @(posedge bit_clk_i) disable iff (lrst_r)
        (lfmt == SAP_FMT_RJ && word_done) |-> pos == slot_r - 6'h01;
    endproperty
    a_rj_tail: assert property (p_rj_tail) else $error("right-justified LSB not last");

    property p_msb_first;
        @(posedge bit_clk_i) disable iff (lrst_r)
        (word_done && !rx_win.right && wl > 5'h01) |=> lword_r[23] == $past(msb_now);
    endproperty
    a_msb_first: assert property (p_msb_first) else $error("MSB not first");

    property p_wl;
        @(posedge bit_clk_i) disable iff (lrst_r)
        word_done |-> wl inside {5'h10, 5'h14, 5'h18};
    endproperty
    a_wl: assert property (p_wl) else $error("illegal word length");

endmodule

`default_nettype wire

// ===== sap_src_model.sv
/*
 * Digital audio source model driving bit clock, frame clock and data.
 * Assumes the bench resolves the shared pins and feeds the data line back.
 */
`timescale 1ns/1ps
`default_nettype none

module sap_src_model (
    input  wire logic sel_i,
    input  wire logic line_i,
    output logic      bclk_o,
    output logic      frame_o,
    output logic      data_o
);
    logic [23:0] cap_l;
    logic [23:0] cap_r;

    initial begin
        bclk_o = 1'b0;
        frame_o = 1'b0;
        data_o = 1'b0;
        cap_l = 24'h000000;
        cap_r = 24'h000000;
    end

    ////////////////////////////////////////////////////////////////
    // Change on falling edge, sample on rising
    // Unused bits toggle so a stale level never looks valid
    task automatic tick(input logic f, input logic d, input logic h,
                        input logic r, input int o);
        frame_o = f;
        data_o = (sel_i && h) ? d : ~data_o;
        #16 bclk_o = 1'b1;
        if (h && r) begin
            cap_r[23-o] = line_i;
        end else if (h) begin
            cap_l[23-o] = line_i;
        end
        #16 bclk_o = 1'b0;
    endtask

    // 64-bit frames per format and length
    // Clock stands still in the gap, one frame per 48 kHz period
    task automatic send(input logic [1:0] fmt, input int wl, input logic [23:0] l,
                        input logic [23:0] r, input int n);
        int   p;
        int   st;
        int   o;
        logic rt;
        logic f;
        repeat (n) begin
            for (p = 0; p < 64; p++) begin
                rt = (p >= 32);
                st = (fmt == 2'h0) ? 0 : (fmt == 2'h1) ? 1 : 32 - wl;
                f = (fmt == 2'h1) ? rt : (fmt == 2'h3) ? (p == 0) : !rt;
                o = (p % 32) - st;
                if (fmt == 2'h3) begin
                    rt = (p > wl);
                    o = rt ? p - wl - 1 : p - 1;
                end
                tick(f, rt ? r[23-o] : l[23-o], (o >= 0 && o < wl), rt, o);
            end
            #18785;
        end
    endtask
endmodule

`default_nettype wire

// ===== test_serial_audio_input_port.sv
/*
 * Self-checking bench of the serial audio input port.
 * Assumes sap_port, its package and the source model are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none

module test_serial_audio_input_port;
    logic        clk_i, rst_i, wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o;
    logic [7:0]  wb_adr_i;
    logic [31:0] wb_dat_i, wb_dat_o, seed;
    logic [3:0]  wb_sel_i;
    logic        bit_clk_i, bit_clk_o, bit_clk_oe_n_o, src_bclk, src_frm, src_dat;
    logic        frame_clk_i, frame_clk_o, frame_clk_oe_n_o, digital_source_select_i;
    logic        serial_sample_line_i, serial_sample_line_o, serial_sample_line_oe_n_o;
    logic [23:0] adc_left_i, adc_right_i, rx_left_o, rx_right_o, last_l, last_r;
    logic        rx_valid_o;
    int          errors, compares, vcnt;

    // Shared pins: whoever enables wins, else the source
    assign bit_clk_i = bit_clk_oe_n_o ? src_bclk : bit_clk_o;
    assign frame_clk_i = frame_clk_oe_n_o ? src_frm : frame_clk_o;
    assign serial_sample_line_i = serial_sample_line_oe_n_o ? src_dat : serial_sample_line_o;

    sap_port i_dut (.clk_i, .rst_i, .wb_adr_i, .wb_dat_i, .wb_dat_o, .wb_we_i,
        .wb_sel_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .bit_clk_i, .bit_clk_o,
        .bit_clk_oe_n_o, .frame_clk_i, .frame_clk_o, .frame_clk_oe_n_o,
        .serial_sample_line_i, .serial_sample_line_o, .serial_sample_line_oe_n_o,
        .digital_source_select_i, .adc_left_i, .adc_right_i, .rx_left_o,
        .rx_right_o, .rx_valid_o);

    sap_src_model i_src (.sel_i(digital_source_select_i), .line_i(serial_sample_line_i),
        .bclk_o(src_bclk), .frame_o(src_frm), .data_o(src_dat));

    initial clk_i = 1'b0;
    always #25 clk_i = ~clk_i;

    always @(posedge clk_i) begin
        if (rx_valid_o === 1'b1) begin
            last_l <= rx_left_o;
            last_r <= rx_right_o;
            vcnt <= vcnt + 1;
        end
    end

    ////////////////////////////////////////////////////////////////
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    function automatic int wlb(input int c);
        return (c == 0) ? 24 : (c == 1) ? 20 : 16;
    endfunction

    function automatic logic [23:0] msk(input int w);
        return 24'hFFFFFF << (24 - w);
    endfunction

    task automatic summarize();
        $display("errors=%0d compares=%0d", errors, compares);
        if (errors == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Classic cycle, held until ack, bounded wait
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_dat_i <= d;
        wb_sel_i <= s;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        if (wb_ack_o !== 1'b1) begin
            errors++;
            summarize();
        end
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        logic [31:0] q;
        wb(1'b0, a, 32'h00000000, 4'hF, q);
        chk(q & m, e);
    endtask

    ////////////////////////////////////////////////////////////////
    initial begin
        logic [31:0] q, l, r;
        int          w, n0;
        seed = 32'h00000014;
        {rst_i, digital_source_select_i} = 2'h3;
        {wb_we_i, wb_cyc_i, wb_stb_i} = 3'h0;
        {wb_adr_i, wb_dat_i, wb_sel_i} = 44'h0;
        {adc_left_i, adc_right_i} = 48'h0;
        {errors, compares, vcnt} = '0;
        {last_l, last_r} = 48'h0;
        fork
            repeat (12) @(posedge clk_i);
            repeat (6) i_src.tick(1'b0, 1'b0, 1'b0, 1'b0, 0);
        join
        rst_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        chk({bit_clk_oe_n_o, frame_clk_oe_n_o, serial_sample_line_oe_n_o}, 3'h7);
        rd(8'h00, 32'hFFFFFFFF, 32'h0);
        wb(1'b1, 8'h00, 32'h0000000F, 4'hE, q);
        rd(8'h00, 32'hFFFFFFFF, 32'h0);
        rd(8'h10, 32'hFFFFFFFF, 32'h0);
        rd(8'h04, 32'h1, 32'h1);
        // Every format with every length code
        for (int f = 0; f < 4; f++) begin
            for (int c = 0; c < 4; c++) begin
                w = wlb(c);
                l = rnd();
                r = rnd();
                n0 = vcnt;
                wb(1'b1, 8'h00, {28'h0, f[1:0], c[1:0]}, 4'h1, q);
                rd(8'h00, 32'hFFFFFFFF, {28'h0, f[1:0], c[1:0]});
                i_src.send(f[1:0], w, l[23:0], r[23:0], 3);
                repeat (2) @(posedge clk_i);
                chk(last_l, l[23:0] & msk(w));
                chk(last_r, r[23:0] & msk(w));
                chk(vcnt > n0, 1);
                rd(8'h08, 32'hFFFFFFFF, l[23:0] & msk(w));
                rd(8'h0C, 32'hFFFFFFFF, r[23:0] & msk(w));
            end
        end
        // Converter samples out while the source is deselected
        digital_source_select_i <= 1'b0;
        adc_left_i <= 24'(rnd());
        adc_right_i <= 24'(rnd());
        repeat (8) @(posedge clk_i);
        chk(serial_sample_line_oe_n_o, 0);
        rd(8'h04, 32'h1, 32'h0);
        wb(1'b1, 8'h00, 32'h00000000, 4'h1, q);
        n0 = vcnt;
        i_src.send(2'h0, 24, 24'h0, 24'h0, 3);
        chk(vcnt, n0);
        chk(i_src.cap_l, adc_left_i);
        chk(i_src.cap_r, adc_right_i);
        @(posedge clk_i);
        digital_source_select_i <= 1'b1;
        repeat (8) @(posedge clk_i);
        chk(serial_sample_line_oe_n_o, 1);
        summarize();
    end
endmodule

`default_nettype wire
